// ---- verilog/adc_power_mode_control.sv ----
// power-mode control: sleep, wake, warm-up and track-and-hold steering
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defs.svh"

// Function
// - mode 00 keeps everything powered; control word resets to normal mode.
// - mode 01 fully powers down at every conversion end.
// - control word keeps its contents through any power-down.
// - autoshutdown power-down puts track-and-hold in hold for its duration.
// - autoshutdown wakes on next start strobe rising edge, back to track.
// - mode 10 powers down all but reference and buffer at conversion end.
// - autostandby holds during standby; rising start edge wakes and tracks.
// - writing mode 11 powers all down at write strobe release, hold.
// - full shutdown stays down in hold until mode bits change.
// - write of 00 in full shutdown powers up at release, back to track.
// - busy goes low at conversion end; auto power-down takes effect there.
// - after reset hold until first rising start edge selects track.
// - control word, mode bits included, captured at write strobe release.
module adc_power_mode_control #(
    parameter int unsigned WAKE_CNT_W    = `WAKE_CNT_W,
    parameter int unsigned WAKE_LONG_CYC = ((`T_WAKE_LONG_MS * `CLK_HZ) + 999) / 1000
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire logic               conversion_start_n,
    input  wire logic               conv_end,
    input  wire logic               cs_n,
    input  wire logic               wr_n,
    input  wire logic               word_mode,
    input  wire logic               hben,
    input  wire logic [`CTRL_W-1:0] wr_data,
    input  wire logic               ext_ref,
    output logic                    busy,
    output logic                    track,
    output logic                    conv_start,
    output logic                    core_power_on,
    output logic                    ref_power_on,
    output logic                    powered_up,
    output logic                    early_start,
    output logic [1:0]              power_mode,
    output logic [`CTRL_W-1:0]      ctrl_word
);

    ////////////////////////////////////////////////////////////////////////
    // derived cycle counts; least times round up, never below one cycle
    localparam int unsigned WAKE_EXT_RAW =
        ((`T_WAKE_EXT_NS * (`CLK_HZ / 1000)) + 999999) / 1000000;
    localparam int unsigned WAKE_INT_RAW =
        ((`T_WAKE_INT_US * `CLK_HZ) + 999999) / 1000000;
    localparam int unsigned WAKE_EXT_CYC = (WAKE_EXT_RAW < 1) ? 1 : WAKE_EXT_RAW;
    localparam int unsigned WAKE_INT_CYC = (WAKE_INT_RAW < 1) ? 1 : WAKE_INT_RAW;

    localparam logic [WAKE_CNT_W-1:0] WAKE_LONG_V = WAKE_CNT_W'(WAKE_LONG_CYC);
    localparam logic [WAKE_CNT_W-1:0] WAKE_EXT_V  = WAKE_CNT_W'(WAKE_EXT_CYC);
    localparam logic [WAKE_CNT_W-1:0] WAKE_INT_V  = WAKE_CNT_W'(WAKE_INT_CYC);

    generate
        if (WAKE_CNT_W < 2 || WAKE_CNT_W > 31) begin : g_chk_w
            $error("warm-up counter width out of range");
        end
        if (WAKE_LONG_CYC < 1 || WAKE_LONG_CYC >= (1 << WAKE_CNT_W)) begin : g_chk_l
            $error("long warm-up count does not fit the counter");
        end
        if (WAKE_INT_CYC >= (1 << WAKE_CNT_W)) begin : g_chk_i
            $error("standby warm-up count does not fit the counter");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // control word store
    pwr_ctrl_if cw ();

    ctrl_word_store u_store (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .cs_n      (cs_n),
        .wr_n      (wr_n),
        .word_mode (word_mode),
        .hben      (hben),
        .wr_data   (wr_data),
        .cw        (cw)
    );

    pwr_pkg::pm_mode_e pm;
    logic              wr_done;

    assign pm      = pwr_pkg::pm_mode_e'(cw.word[`PM_HI_POS:`PM_LO_POS]);
    assign wr_done = ce & cw.write_done;

    ////////////////////////////////////////////////////////////////////////
    // start strobe edges; first cycle after reset only samples, so a pin
    // that is already low does not fake the first falling edge
    logic primed_r;
    logic primed_nxt;
    logic cst_prev_r;
    logic cst_prev_nxt;
    logic cst_rise;
    logic cst_fall;
    logic end_ev;

    always_comb begin
        primed_nxt   = primed_r;
        cst_prev_nxt = cst_prev_r;
        if (ce) begin
            primed_nxt   = 1'b1;
            cst_prev_nxt = conversion_start_n;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            primed_r   <= 1'b0;
            cst_prev_r <= 1'b1;
        end else begin
            primed_r   <= primed_nxt;
            cst_prev_r <= cst_prev_nxt;
        end
    end

    assign cst_rise = ce & primed_r & ~cst_prev_r & conversion_start_n;
    assign cst_fall = ce & primed_r & cst_prev_r & ~conversion_start_n;

    ////////////////////////////////////////////////////////////////////////
    // power state
    pwr_pkg::pstate_e      st_r;
    pwr_pkg::pstate_e      st_nxt;
    logic                  core_pwr_r;
    logic                  core_pwr_nxt;
    logic                  ref_pwr_r;
    logic                  ref_pwr_nxt;
    logic                  wake_go;
    logic [WAKE_CNT_W-1:0] wake_len;
    logic                  busy_r;

    assign end_ev = ce & conv_end & busy_r;

    always_comb begin
        st_nxt   = st_r;
        wake_go  = 1'b0;
        wake_len = WAKE_LONG_V;
        if (ce) begin
            case (st_r)
                pwr_pkg::PS_ACTIVE: begin
                    if (wr_done && pm == pwr_pkg::PM_FULL_OFF) begin
                        st_nxt = pwr_pkg::PS_FULL_OFF;
                    end else if (end_ev && pm == pwr_pkg::PM_AUTO_SHUT) begin
                        st_nxt = pwr_pkg::PS_SHUTDOWN;
                    end else if (end_ev && pm == pwr_pkg::PM_AUTO_STBY) begin
                        st_nxt = pwr_pkg::PS_STANDBY;
                    end
                    // normal mode and start edges leave power alone
                end
                pwr_pkg::PS_SHUTDOWN: begin
                    if (wr_done && pm == pwr_pkg::PM_FULL_OFF) begin
                        st_nxt = pwr_pkg::PS_FULL_OFF;
                    end else if (cst_rise) begin
                        st_nxt  = pwr_pkg::PS_ACTIVE;
                        wake_go = 1'b1;
                    end
                end
                pwr_pkg::PS_STANDBY: begin
                    if (wr_done && pm == pwr_pkg::PM_FULL_OFF) begin
                        st_nxt = pwr_pkg::PS_FULL_OFF;
                    end else if (cst_rise) begin
                        st_nxt   = pwr_pkg::PS_ACTIVE;
                        wake_go  = 1'b1;
                        wake_len = ext_ref ? WAKE_EXT_V : WAKE_INT_V;
                    end
                end
                pwr_pkg::PS_FULL_OFF: begin
                    // start edges are ignored; only a mode change wakes
                    if (wr_done && pm != pwr_pkg::PM_FULL_OFF) begin
                        st_nxt  = pwr_pkg::PS_ACTIVE;
                        wake_go = 1'b1;
                    end
                end
                default: begin
                    st_nxt = pwr_pkg::PS_ACTIVE;
                end
            endcase
        end
        core_pwr_nxt = (st_nxt == pwr_pkg::PS_ACTIVE);
        ref_pwr_nxt  = (st_nxt == pwr_pkg::PS_ACTIVE) ||
                       (st_nxt == pwr_pkg::PS_STANDBY);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r       <= pwr_pkg::PS_ACTIVE;
            core_pwr_r <= 1'b1;
            ref_pwr_r  <= 1'b1;
        end else begin
            st_r       <= st_nxt;
            core_pwr_r <= core_pwr_nxt;
            ref_pwr_r  <= ref_pwr_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // warm-up tracking; informative only, the host still owns the wait
    logic [WAKE_CNT_W-1:0] wcnt_r;
    logic [WAKE_CNT_W-1:0] wcnt_nxt;
    logic                  pwr_ok_r;
    logic                  pwr_ok_nxt;

    always_comb begin
        wcnt_nxt = wcnt_r;
        if (ce) begin
            if (st_nxt != pwr_pkg::PS_ACTIVE) begin
                wcnt_nxt = '0;
            end else if (wake_go) begin
                wcnt_nxt = wake_len;
            end else if (wcnt_r != '0) begin
                wcnt_nxt = wcnt_r - 1'b1;
            end
        end
        pwr_ok_nxt = (st_nxt == pwr_pkg::PS_ACTIVE) && (wcnt_nxt == '0);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wcnt_r   <= '0;
            pwr_ok_r <= 1'b1;
        end else begin
            wcnt_r   <= wcnt_nxt;
            pwr_ok_r <= pwr_ok_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // conversion and track-and-hold
    logic busy_nxt;
    logic track_r;
    logic track_nxt;
    logic start_r;
    logic start_nxt;
    logic early_r;
    logic early_nxt;

    always_comb begin
        busy_nxt  = busy_r;
        track_nxt = track_r;
        early_nxt = early_r;
        start_nxt = start_r;
        if (ce) begin
            // pulse ends at the next enabled edge, so a frozen clock holds it
            start_nxt = 1'b0;
            if (st_nxt == pwr_pkg::PS_FULL_OFF) begin
                // a shutdown write drops any conversion in flight
                busy_nxt  = 1'b0;
                track_nxt = 1'b0;
            end else if (st_r == pwr_pkg::PS_FULL_OFF) begin
                track_nxt = 1'b1;
            end else if (cst_fall && st_r == pwr_pkg::PS_ACTIVE && !busy_r) begin
                busy_nxt  = 1'b1;
                track_nxt = 1'b0;
                start_nxt = 1'b1;
                // a start inside the warm-up gives a suspect result
                early_nxt = (wcnt_r != '0);
            end else if (end_ev) begin
                busy_nxt  = 1'b0;
                // auto modes stay in hold while asleep
                track_nxt = (st_nxt == pwr_pkg::PS_ACTIVE);
            end else if (cst_rise && !busy_r) begin
                track_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            busy_r  <= 1'b0;
            track_r <= 1'b0;
            start_r <= 1'b0;
            early_r <= 1'b0;
        end else begin
            busy_r  <= busy_nxt;
            track_r <= track_nxt;
            start_r <= start_nxt;
            early_r <= early_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign busy          = busy_r;
    assign track         = track_r;
    assign conv_start    = start_r;
    assign core_power_on = core_pwr_r;
    assign ref_power_on  = ref_pwr_r;
    assign powered_up    = pwr_ok_r;
    assign early_start   = early_r;
    assign power_mode    = cw.word[`PM_HI_POS:`PM_LO_POS];
    assign ctrl_word     = cw.word;

endmodule

`default_nettype wire

// ---- verilog/pwr_defs.svh ----
// constants for the converter power-mode control block
`ifndef PWR_DEFS_SVH
`define PWR_DEFS_SVH

// control word layout
`define CTRL_W          12
`define CTRL_RST        12'h000
`define PM_HI_POS       11
`define PM_LO_POS       10
`define BYTE_W          8

// clock rate in hz
`define CLK_HZ          10000000

// power-up times as printed
`define T_WAKE_LONG_MS  10
`define T_WAKE_EXT_NS   600
`define T_WAKE_INT_US   7

// warm-up counter width default
`define WAKE_CNT_W      17

`endif

// ---- verilog/pwr_pkg.sv ----
// types for the converter power-mode control block
`default_nettype none

package pwr_pkg;

    typedef enum logic [1:0] {
        PM_NORMAL    = 2'h0,
        PM_AUTO_SHUT = 2'h1,
        PM_AUTO_STBY = 2'h2,
        PM_FULL_OFF  = 2'h3
    } pm_mode_e;

    typedef enum logic [3:0] {
        PS_ACTIVE   = 4'h1,
        PS_SHUTDOWN = 4'h2,
        PS_STANDBY  = 4'h4,
        PS_FULL_OFF = 4'h8
    } pstate_e;

endpackage

`default_nettype wire

// ---- verilog/pwr_ctrl_if.sv ----
// carrier between the control word store and the power-mode logic
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defs.svh"

interface pwr_ctrl_if;
    logic [`CTRL_W-1:0] word;
    logic               write_done;

    modport store (
        output word,
        output write_done
    );

    modport user (
        input  word,
        input  write_done
    );
endinterface

`default_nettype wire

// ---- verilog/ctrl_word_store.sv ----
// control word store, word and byte writes, committed at write strobe release
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defs.svh"

module ctrl_word_store (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire logic              cs_n,
    input  wire logic              wr_n,
    input  wire logic              word_mode,
    input  wire logic              hben,
    input  wire logic [`CTRL_W-1:0] wr_data,
    pwr_ctrl_if.store              cw
);

    ////////////////////////////////////////////////////////////////////////
    logic                strobe;
    logic                release_ev;
    logic                strobe_prev_r;
    logic                strobe_prev_nxt;
    logic [`CTRL_W-1:0]  word_r;
    logic [`CTRL_W-1:0]  word_nxt;
    logic                done_r;
    logic                done_nxt;
    logic [`CTRL_W-1:0]  bit_en;
    logic [`CTRL_W-1:0]  bit_src;

    // chip select and write are gated together
    assign strobe     = ~cs_n & ~wr_n;
    assign release_ev = strobe_prev_r & ~strobe;

    ////////////////////////////////////////////////////////////////////////
    // byte mode: high byte lands on bits 11:8, its top four data bits dropped
    genvar i;
    generate
        for (i = 0; i < `CTRL_W; i++) begin : g_bit
            if (i < `BYTE_W) begin : g_lo
                assign bit_en[i]  = word_mode | ~hben;
                assign bit_src[i] = wr_data[i];
            end else begin : g_hi
                assign bit_en[i]  = word_mode | hben;
                assign bit_src[i] = word_mode ? wr_data[i] : wr_data[i-`BYTE_W];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        strobe_prev_nxt = strobe_prev_r;
        word_nxt        = word_r;
        done_nxt        = done_r;
        if (ce) begin
            strobe_prev_nxt = strobe;
            done_nxt        = release_ev;
            if (release_ev) begin
                word_nxt = (word_r & ~bit_en) | (bit_src & bit_en);
            end
        end
    end

    // no power state touches this register, so settings survive sleep
    always_ff @(posedge clk) begin
        if (rst) begin
            strobe_prev_r <= 1'b0;
            word_r        <= `CTRL_RST;
            done_r        <= 1'b0;
        end else begin
            strobe_prev_r <= strobe_prev_nxt;
            word_r        <= word_nxt;
            done_r        <= done_nxt;
        end
    end

    assign cw.word       = word_r;
    assign cw.write_done = done_r;

endmodule

`default_nettype wire

// ---- verif/adc_power_mode_control_sva.sv ----
// assertions on the power-mode control ports
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defs.svh"

module adc_power_mode_control_sva #(
    parameter int unsigned WAKE_LONG_CYC = 100000
) (
    input wire logic               clk,
    input wire logic               rst,
    input wire logic               ce,
    input wire logic               conversion_start_n,
    input wire logic               conv_end,
    input wire logic               cs_n,
    input wire logic               wr_n,
    input wire logic               word_mode,
    input wire logic               hben,
    input wire logic [`CTRL_W-1:0] wr_data,
    input wire logic               ext_ref,
    input wire logic               busy,
    input wire logic               track,
    input wire logic               conv_start,
    input wire logic               core_power_on,
    input wire logic               ref_power_on,
    input wire logic               powered_up,
    input wire logic               early_start,
    input wire logic [1:0]         power_mode,
    input wire logic [`CTRL_W-1:0] ctrl_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
////////////////////////////////////////////////////////////////////////////////
    // release of the write strobe, the only commit point
    sequence wr_release;
        (!cs_n && !wr_n) ##1 ((cs_n || wr_n) && ce);
    endsequence
    sequence mode_leave_off;
        (power_mode == 2'h3) ##1 (power_mode == 2'h0 && ce);
    endsequence
////////////////////////////////////////////////////////////////////////////////
    a_normal_stays_on: assert property ((power_mode == 2'h0 && core_power_on) |=> core_power_on)
        else $error("normal mode lost power");
    a_shut_at_end: assert property ((ce && busy && conv_end && power_mode == 2'h1)
        |=> !core_power_on && !ref_power_on && !track && !busy)
        else $error("autoshutdown did not power down at conversion end");
    a_stby_at_end: assert property ((ce && busy && conv_end && power_mode == 2'h2)
        |=> !core_power_on && ref_power_on && !track)
        else $error("autostandby did not enter standby at conversion end");
    a_asleep_holds: assert property (!core_power_on |-> !track)
        else $error("tracking while powered down");
    a_wake_on_rise: assert property ((ce && $past(ce) && !$past(rst) && !core_power_on
        && power_mode inside {2'h1, 2'h2} && $rose(conversion_start_n))
        |=> core_power_on && ref_power_on && track)
        else $error("no wake on start strobe rise");
    a_full_off_wr: assert property ((wr_release ##0 (word_mode && wr_data[11:10] == 2'h3))
        |=> (power_mode == 2'h3) ##1 (!core_power_on && !ref_power_on && !track))
        else $error("full shutdown write did not power down");
    a_full_off_stays: assert property ((power_mode == 2'h3 && !core_power_on) |=> !core_power_on)
        else $error("woke while in full shutdown");
    a_exit_full_off: assert property (mode_leave_off |=> core_power_on && ref_power_on && track)
        else $error("no power-up after leaving full shutdown");
    a_word_capture: assert property ((wr_release ##0 word_mode)
        |=> ctrl_word == $past(wr_data) && power_mode == ctrl_word[`PM_HI_POS:`PM_LO_POS])
        else $error("control word not captured at write release");
    a_busy_ends: assert property ((ce && busy && conv_end) |=> !busy)
        else $error("busy did not fall at conversion end");
    a_start_taken: assert property ((ce && $past(ce) && !$past(rst)
        && $fell(conversion_start_n) && core_power_on && !busy)
        |=> busy && !track && conv_start)
        else $error("start strobe fall not taken");
    a_wake_not_ready: assert property ($rose(core_power_on) |-> !powered_up)
        else $error("powered_up set at the start of warm-up");
    a_early_flag: assert property ($rose(conv_start)
        |-> early_start == !$past(powered_up))
        else $error("early start flag does not match warm-up");
endmodule

bind adc_power_mode_control adc_power_mode_control_sva #(.WAKE_LONG_CYC(WAKE_LONG_CYC)) u_sva (
    .clk(clk), .rst(rst), .ce(ce), .conversion_start_n(conversion_start_n),
    .conv_end(conv_end), .cs_n(cs_n), .wr_n(wr_n), .word_mode(word_mode), .hben(hben),
    .wr_data(wr_data), .ext_ref(ext_ref), .busy(busy), .track(track),
    .conv_start(conv_start), .core_power_on(core_power_on), .ref_power_on(ref_power_on),
    .powered_up(powered_up), .early_start(early_start), .power_mode(power_mode),
    .ctrl_word(ctrl_word));

`default_nettype wire

// ---- verif/adc_host_model.sv ----
// host model: parallel write cycles and start strobe
`timescale 1ns/1ps
`default_nettype none

module adc_host_model (
    input  wire logic        clk,
    output logic             cs_n,
    output logic             wr_n,
    output logic             word_mode,
    output logic             hben,
    output logic [11:0]      wr_data,
    output logic             conversion_start_n,
    output logic             ext_ref
);
    initial begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        word_mode = 1'b1;
        hben = 1'b0;
        wr_data = 12'h000;
        conversion_start_n = 1'b0;
        ext_ref = 1'b1;
    end
////////////////////////////////////////////////////////////////////////////////
    // warm-up waits are the host's job, the device never refuses
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // data held through the release edge, one idle cycle after
    task automatic strobe(input logic [11:0] d);
        @(negedge clk);
        wr_data = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        @(negedge clk);
        cs_n = 1'b1;
        wr_n = 1'b1;
        @(negedge clk);
    endtask
    task automatic write_word(input logic [11:0] d);
        word_mode = 1'b1;
        strobe(d);
    endtask
    task automatic write_byte(input logic hi, input logic [7:0] d);
        word_mode = 1'b0;
        hben = hi;
        strobe({4'h0, d});
    endtask
    task automatic start_fall();
        @(negedge clk);
        conversion_start_n = 1'b0;
    endtask
    task automatic start_rise();
        @(negedge clk);
        conversion_start_n = 1'b1;
    endtask
endmodule

`default_nettype wire

// ---- verif/adc_power_mode_control_bench.sv ----
// self-checking bench for the power-mode control block
`timescale 1ns/1ps
`default_nettype none
`include "pwr_defs.svh"

module adc_power_mode_control_bench;
    localparam int unsigned WAKE = 20;
    logic               clk = 1'b0;
    logic               rst = 1'b1;
    logic               ce = 1'b1;
    logic               conv_end = 1'b0;
    logic               cs_n, wr_n, word_mode, hben, conversion_start_n, ext_ref;
    logic [11:0]        wr_data;
    logic               busy, track, conv_start, core_power_on, ref_power_on;
    logic               powered_up, early_start;
    logic [1:0]         power_mode;
    logic [11:0]        ctrl_word;
    logic [15:0]        q[$];
    logic [15:0]        last, exp_v;
    logic [11:0]        exp_word = 12'h000;
    logic [3:0]         pw = 4'b1100;
    int                 n_fail = 0;
    int                 n_tests = 0;
    integer             seed = 75;
    wire logic [15:0]   seen = {ctrl_word, core_power_on, ref_power_on, track, busy};

    initial begin
        forever #50 clk = ~clk;
    end

    adc_host_model u_host (.clk(clk), .cs_n(cs_n), .wr_n(wr_n), .word_mode(word_mode),
        .hben(hben), .wr_data(wr_data), .conversion_start_n(conversion_start_n),
        .ext_ref(ext_ref));

    adc_power_mode_control #(.WAKE_LONG_CYC(WAKE)) u_dut (.clk(clk), .rst(rst), .ce(ce),
        .conversion_start_n(conversion_start_n), .conv_end(conv_end), .cs_n(cs_n),
        .wr_n(wr_n), .word_mode(word_mode), .hben(hben), .wr_data(wr_data),
        .ext_ref(ext_ref), .busy(busy), .track(track), .conv_start(conv_start),
        .core_power_on(core_power_on), .ref_power_on(ref_power_on),
        .powered_up(powered_up), .early_start(early_start), .power_mode(power_mode),
        .ctrl_word(ctrl_word));
////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
        end
    endtask
    // power state {core, ref, track, busy} with the word expected beside it
    task automatic note(input logic [3:0] p);
        pw = p;
        q.push_back({exp_word, p});
    endtask
    task automatic wr(input logic [11:0] d);
        if (d !== exp_word) begin
            exp_word = d;
            note(pw);
        end
        u_host.write_word(d);
    endtask
    task automatic wrb(input logic hi, input logic [7:0] d);
        logic [11:0] nw;
        nw = hi ? {d[3:0], exp_word[7:0]} : {exp_word[11:8], d};
        if (nw !== exp_word) begin
            exp_word = nw;
            note(pw);
        end
        u_host.write_byte(hi, d);
    endtask
    task automatic conv(input logic [3:0] after);
        note(4'b1101);
        u_host.start_fall();
        u_host.wait_cyc(3);
        note(after);
        conv_end = 1'b1;
        @(negedge clk);
        conv_end = 1'b0;
    endtask
    // random clock-enable gaps, only where no write or conversion end is due
    task automatic stall(input int n);
        repeat (n) begin
            @(negedge clk);
            ce = 1'($random(seed));
        end
        @(negedge clk);
        ce = 1'b1;
    endtask
    task automatic complete_run();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    // every change of the watched outputs consumes the oldest note
    always @(posedge clk) begin
        #1;
        if (rst) begin
            last = seen;
        end else if (seen !== last) begin
            exp_v = (q.size() != 0) ? q.pop_front() : last;
            check(seen, exp_v);
            last = seen;
        end
    end

    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(seen, 16'h000c);
        note(4'b1110);
        u_host.start_rise();
        u_host.wait_cyc(3);
        conv(4'b1110);
        u_host.start_rise();
        u_host.wait_cyc(4);
        wr({2'h1, 10'($random(seed))});
        conv(4'b0000);
        u_host.wait_cyc(6);
        note(4'b1110);
        u_host.start_rise();
        stall(WAKE + 5);
        wrb(1'b0, 8'($random(seed)));
        wrb(1'b1, {4'h0, 2'h2, 2'($random(seed))});
        conv(4'b0100);
        u_host.wait_cyc(4);
        u_host.ext_ref = 1'($random(seed));
        note(4'b1110);
        u_host.start_rise();
        u_host.wait_cyc(75);
        check({15'h0000, powered_up}, 16'h0001);
        wr({2'h3, exp_word[9:0]});
        note(4'b0000);
        u_host.start_fall();
        u_host.wait_cyc(3);
        u_host.start_rise();
        u_host.wait_cyc(3);
        wr({2'h0, exp_word[9:0]});
        note(4'b1110);
        u_host.wait_cyc(WAKE + 5);
        conv(4'b1110);
        u_host.wait_cyc(4);
        check(16'(q.size()), 16'h0000);
        check({15'h0000, early_start}, 16'h0000);
        complete_run();
    end
endmodule

`default_nettype wire
